/* common/occ_defs.svh */
// Constants for the operator console control block
`ifndef OCC_DEFS_SVH
`define OCC_DEFS_SVH
`define OCC_WORD_W 15
`define OCC_ADDR_W 13
`define OCC_MEM_WORDS 8192
`define OCC_BOOT_ADDR 13'h0000
`define OCC_MDR_RST 15'h0000
`define OCC_MAR_RST 15'h0000
`define OCC_CORE_TIME_NS 6000
`define OCC_CLK_NS 25
`define OCC_CORE_CYC ((`OCC_CORE_TIME_NS + `OCC_CLK_NS - 1) / `OCC_CLK_NS)
`define OCC_CNT_W 8
`endif

/* common/occ_pkg.sv */
// Types shared by the operator console control block
package occ_pkg;
    typedef enum logic [1:0] {
        OCC_XFER_IDLE,
        OCC_XFER_WRITE,
        OCC_XFER_READ_RESTORE
    } occ_xfer_t;

    typedef enum logic [2:0] {
        OCC_REG_LOGAND,
        OCC_REG_ACC,
        OCC_REG_MAR,
        OCC_REG_PROD,
        OCC_REG_IO
    } occ_reg_t;
endpackage : occ_pkg

/* rtl/occ_core_mem.sv */
// Core memory array of 15-bit words with a one-cycle read
`timescale 1ns/1ps
`include "occ_defs.svh"
module occ_core_mem (
    input wire logic clock,
    input wire logic wr_en,
    input wire logic [`OCC_ADDR_W-1:0] addr,
    input wire logic [`OCC_WORD_W-1:0] wr_data,
    output logic [`OCC_WORD_W-1:0] rd_data
);
    logic [`OCC_WORD_W-1:0] mem [0:`OCC_MEM_WORDS-1];

    // Power-up contents are undefined, as in real cores; boot must not depend on them
    always_ff @(posedge clock)
    begin
        if (wr_en)
        begin
            mem[addr] <= wr_data;
        end
        rd_data <= mem[addr];
    end
endmodule : occ_core_mem

/* rtl/occ_console.sv */
// Operator and maintenance panel control around core memory and working registers
`timescale 1ns/1ps
`include "occ_defs.svh"
module occ_console (
    input wire logic clock,
    input wire logic rst,
    input wire logic [`OCC_WORD_W-1:0] toggle_sw,
    input wire logic operator_btn,
    input wire logic maint_load_sw,
    input wire logic clear_write_btn,
    input wire logic read_restore_btn,
    input wire logic sw_to_mdr_btn,
    input wire logic [4:0] mdr_to_reg_btn,
    input wire logic [4:0] reg_to_mdr_btn,
    input wire logic intr_ack,
    output logic [`OCC_WORD_W-1:0] lamps,
    output logic intr_req,
    output logic [`OCC_WORD_W-1:0] sw_capture,
    output logic boot_start,
    output logic [`OCC_ADDR_W-1:0] boot_addr,
    output logic mem_busy,
    output logic [`OCC_WORD_W-1:0] mar_out,
    output logic [`OCC_WORD_W-1:0] logand_out,
    output logic [`OCC_WORD_W-1:0] acc_out,
    output logic [`OCC_WORD_W-1:0] prod_out,
    output logic [`OCC_WORD_W-1:0] io_out
);
    localparam int unsigned NBTN = 14;
    localparam logic [`OCC_CNT_W-1:0] CORE_CYC = `OCC_CNT_W'(`OCC_CORE_CYC);

    // Two-stage synchronisers for every panel input
    logic [NBTN-1:0] btn_raw;
    logic [NBTN-1:0] btn_s1_r;
    logic [NBTN-1:0] btn_s2_r;
    logic [NBTN-1:0] btn_d_r;
    logic [NBTN-1:0] btn_rise;
    logic [`OCC_WORD_W-1:0] sw_s1_r;
    logic [`OCC_WORD_W-1:0] sw_s2_r;
    logic load_s1_r;
    logic load_s2_r;

    assign btn_raw = {reg_to_mdr_btn, mdr_to_reg_btn, sw_to_mdr_btn, read_restore_btn,
                      clear_write_btn, operator_btn};

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            btn_s1_r <= '0;
            btn_s2_r <= '0;
            btn_d_r <= '0;
            sw_s1_r <= '0;
            sw_s2_r <= '0;
            load_s1_r <= 1'b0;
            load_s2_r <= 1'b0;
        end
        else
        begin
            btn_s1_r <= btn_raw;
            btn_s2_r <= btn_s1_r;
            btn_d_r <= btn_s2_r;
            sw_s1_r <= toggle_sw;
            sw_s2_r <= sw_s1_r;
            load_s1_r <= maint_load_sw;
            load_s2_r <= load_s1_r;
        end
    end

    // One action per press: only the rising edge counts
    generate
        for (genvar g = 0; g < NBTN; g++)
        begin : g_edge
            assign btn_rise[g] = btn_s2_r[g] & ~btn_d_r[g];
        end
    endgenerate

    logic op_press;
    logic cw_press;
    logic rr_press;
    logic sw_press;
    logic [4:0] to_reg_press;
    logic [4:0] from_reg_press;
    assign op_press = btn_rise[0];
    assign cw_press = btn_rise[1];
    assign rr_press = btn_rise[2];
    assign sw_press = btn_rise[3];
    assign to_reg_press = btn_rise[8:4];
    assign from_reg_press = btn_rise[13:9];

    function automatic logic [`OCC_ADDR_W-1:0] core_addr(input logic [`OCC_WORD_W-1:0] a);
        core_addr = a[`OCC_ADDR_W-1:0];
    endfunction : core_addr

    // Core cycle sequencer
    occ_pkg::occ_xfer_t xfer_r;
    logic [`OCC_CNT_W-1:0] cnt_r;
    logic [`OCC_WORD_W-1:0] mdr_r;
    logic [`OCC_WORD_W-1:0] mar_r;
    logic [`OCC_WORD_W-1:0] wregs_r [5];
    logic mem_wr;
    logic [`OCC_WORD_W-1:0] mem_rd;
    logic last_cyc;

    assign last_cyc = (cnt_r == CORE_CYC - `OCC_CNT_W'(1));

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            xfer_r <= occ_pkg::OCC_XFER_IDLE;
            cnt_r <= '0;
        end
        else
        begin
            unique case (xfer_r)
                occ_pkg::OCC_XFER_IDLE:
                begin
                    cnt_r <= '0;
                    if (cw_press)
                    begin
                        xfer_r <= occ_pkg::OCC_XFER_WRITE;
                    end
                    else if (rr_press)
                    begin
                        xfer_r <= occ_pkg::OCC_XFER_READ_RESTORE;
                    end
                end
                occ_pkg::OCC_XFER_WRITE, occ_pkg::OCC_XFER_READ_RESTORE:
                begin
                    cnt_r <= cnt_r + `OCC_CNT_W'(1);
                    if (last_cyc)
                    begin
                        xfer_r <= occ_pkg::OCC_XFER_IDLE;
                    end
                end
            endcase
        end
    end

    // Read sample at cycle 1 (array has one-cycle latency); rewrite in the last cycle
    logic rd_sample;
    assign rd_sample = (xfer_r == occ_pkg::OCC_XFER_READ_RESTORE) && (cnt_r == `OCC_CNT_W'(1));
    assign mem_wr = (xfer_r != occ_pkg::OCC_XFER_IDLE) && last_cyc;

    occ_core_mem u_mem (
        .clock(clock),
        .wr_en(mem_wr),
        .addr(core_addr(mar_r)),
        .wr_data(mdr_r),
        .rd_data(mem_rd)
    );

    // Memory data register: cleared then loaded for a read-restore; panel transfers only while idle
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            mdr_r <= `OCC_MDR_RST;
        end
        else if (rr_press && xfer_r == occ_pkg::OCC_XFER_IDLE && !cw_press)
        begin
            mdr_r <= '0;
        end
        else if (rd_sample)
        begin
            mdr_r <= mem_rd;
        end
        else if (xfer_r == occ_pkg::OCC_XFER_IDLE && sw_press)
        begin
            mdr_r <= sw_s2_r;
        end
        else if (xfer_r == occ_pkg::OCC_XFER_IDLE)
        begin
            for (int i = 0; i < 5; i++)
            begin
                if (from_reg_press[i])
                begin
                    mdr_r <= wregs_r[i];
                end
            end
        end
    end

    // Working registers; index order follows occ_reg_t
    always_ff @(posedge clock)
    begin
        if (rst || boot_start)
        begin
            for (int i = 0; i < 5; i++)
            begin
                wregs_r[i] <= '0;
            end
        end
        else if (xfer_r == occ_pkg::OCC_XFER_IDLE)
        begin
            for (int i = 0; i < 5; i++)
            begin
                if (to_reg_press[i])
                begin
                    wregs_r[i] <= mdr_r;
                end
            end
        end
    end
    assign mar_r = wregs_r[occ_pkg::OCC_REG_MAR];

    // Operator button: interrupt in normal mode, bootstrap start in loading mode
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            intr_req <= 1'b0;
            sw_capture <= '0;
            boot_start <= 1'b0;
            boot_addr <= `OCC_BOOT_ADDR;
        end
        else
        begin
            boot_start <= op_press && load_s2_r;
            if (op_press && !load_s2_r)
            begin
                intr_req <= 1'b1;
                sw_capture <= sw_s2_r;
            end
            else if (intr_ack)
            begin
                intr_req <= 1'b0;
            end
        end
    end

    // Register-driven outputs
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            lamps <= '0;
            mem_busy <= 1'b0;
            mar_out <= '0;
            logand_out <= '0;
            acc_out <= '0;
            prod_out <= '0;
            io_out <= '0;
        end
        else
        begin
            lamps <= mdr_r;
            mem_busy <= (xfer_r != occ_pkg::OCC_XFER_IDLE);
            mar_out <= wregs_r[occ_pkg::OCC_REG_MAR];
            logand_out <= wregs_r[occ_pkg::OCC_REG_LOGAND];
            acc_out <= wregs_r[occ_pkg::OCC_REG_ACC];
            prod_out <= wregs_r[occ_pkg::OCC_REG_PROD];
            io_out <= wregs_r[occ_pkg::OCC_REG_IO];
        end
    end

    a_lamp_follow: assert property (@(posedge clock) disable iff (rst)
        ##1 lamps == $past(mdr_r)) else $error("lamps do not follow data register");
    a_intr_capture: assert property (@(posedge clock) disable iff (rst)
        op_press && !load_s2_r |=> intr_req && sw_capture == $past(sw_s2_r))
        else $error("interrupt or capture missing");
    a_boot_preset: assert property (@(posedge clock) disable iff (rst)
        op_press && load_s2_r |=> boot_start ##1 mar_r == '0)
        else $error("boot start missing");
    a_boot_nointr: assert property (@(posedge clock) disable iff (rst)
        op_press && load_s2_r && !intr_req |=> !intr_req)
        else $error("interrupt in loading mode");
    sequence s_cw_start;
        xfer_r == occ_pkg::OCC_XFER_IDLE && cw_press;
    endsequence
    a_write_once: assert property (@(posedge clock) disable iff (rst)
        s_cw_start |=> !mem_wr [*8] ##[1:300] mem_wr) else $error("core write not done");
    a_rr_clear: assert property (@(posedge clock) disable iff (rst)
        xfer_r == occ_pkg::OCC_XFER_IDLE && rr_press && !cw_press |=> mdr_r == '0)
        else $error("data register not cleared");
    a_rr_rewrite: assert property (@(posedge clock) disable iff (rst)
        rd_sample |-> ##238 (mem_wr && mdr_r == $past(mem_rd, 238)))
        else $error("read not restored");
    a_busy_excl: assert property (@(posedge clock) disable iff (rst)
        xfer_r != occ_pkg::OCC_XFER_IDLE && sw_press && !rd_sample |=> $stable(mdr_r))
        else $error("transfer during core cycle");
    a_mar_addr: assert property (@(posedge clock) disable iff (rst)
        boot_start |=> mar_r == '0) else $error("address not preset");
endmodule : occ_console

/* sim/occ_panel_model.sv */
// Behavioural operator and maintenance panel that drives the console
`timescale 1ns/1ps
`include "occ_defs.svh"
module occ_panel_model (
    input wire logic clock,
    output logic [`OCC_WORD_W-1:0] toggle_sw,
    output logic operator_btn,
    output logic maint_load_sw,
    output logic clear_write_btn,
    output logic read_restore_btn,
    output logic sw_to_mdr_btn,
    output logic [4:0] mdr_to_reg_btn,
    output logic [4:0] reg_to_mdr_btn
);
    // Bits: 0 operator, 1 clear-write, 2 read-restore, 3 switches, 8:4 to regs, 13:9 from regs
    logic [13:0] btn_r = 14'h0000;
    initial toggle_sw = 15'h0000;
    initial maint_load_sw = 1'b0;
    assign operator_btn = btn_r[0];
    assign clear_write_btn = btn_r[1];
    assign read_restore_btn = btn_r[2];
    assign sw_to_mdr_btn = btn_r[3];
    assign mdr_to_reg_btn = btn_r[8:4];
    assign reg_to_mdr_btn = btn_r[13:9];

    task set_sw(input logic [14:0] value);
        toggle_sw = value;
    endtask : set_sw

    // Held six cycles so the two-stage synchroniser and edge detect see it; a real finger is slower still
    task press(input logic [13:0] mask);
    begin
        @(posedge clock);
        #1;
        btn_r = mask;
        repeat (6) @(posedge clock);
        #1;
        btn_r = 14'h0000;
        repeat (4) @(posedge clock);
        #1;
    end
    endtask : press
endmodule : occ_panel_model

/* sim/test_operator_console_control.sv */
// Self-checking bench for the operator console control block
`timescale 1ns/1ps
`include "occ_defs.svh"
module test_operator_console_control;
    localparam logic [13:0] OP = 14'h0001;
    localparam logic [13:0] CW = 14'h0002;
    localparam logic [13:0] RR = 14'h0004;
    localparam logic [13:0] SM = 14'h0008;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic intr_ack = 1'b0;
    logic [14:0] toggle_sw, lamps, sw_capture, mar_out, logand_out, acc_out, prod_out, io_out;
    logic operator_btn, maint_load_sw, clear_write_btn, read_restore_btn, sw_to_mdr_btn;
    logic intr_req, boot_start, mem_busy;
    logic [4:0] mdr_to_reg_btn, reg_to_mdr_btn;
    logic [12:0] boot_addr;
    logic [14:0] wreg [5];
    int fail_count = 0;
    int check_count = 0;
    int cycle_count = 0;
    int boot_cnt = 0;

    always #12.5 clock = ~clock;

    occ_panel_model panel_u (.clock(clock), .toggle_sw(toggle_sw), .operator_btn(operator_btn),
        .maint_load_sw(maint_load_sw), .clear_write_btn(clear_write_btn), .read_restore_btn(read_restore_btn),
        .sw_to_mdr_btn(sw_to_mdr_btn), .mdr_to_reg_btn(mdr_to_reg_btn), .reg_to_mdr_btn(reg_to_mdr_btn));

    occ_console dut_u (.clock(clock), .rst(rst), .toggle_sw(toggle_sw), .operator_btn(operator_btn),
        .maint_load_sw(maint_load_sw), .clear_write_btn(clear_write_btn), .read_restore_btn(read_restore_btn),
        .sw_to_mdr_btn(sw_to_mdr_btn), .mdr_to_reg_btn(mdr_to_reg_btn), .reg_to_mdr_btn(reg_to_mdr_btn),
        .intr_ack(intr_ack), .lamps(lamps), .intr_req(intr_req), .sw_capture(sw_capture),
        .boot_start(boot_start), .boot_addr(boot_addr), .mem_busy(mem_busy), .mar_out(mar_out),
        .logand_out(logand_out), .acc_out(acc_out), .prod_out(prod_out), .io_out(io_out));

    assign wreg[0] = logand_out;
    assign wreg[1] = acc_out;
    assign wreg[2] = mar_out;
    assign wreg[3] = prod_out;
    assign wreg[4] = io_out;

    task conclude;
    begin
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    end
    endtask : conclude

    // Boot pulse lasts one cycle, so it is counted rather than sampled
    always @(posedge clock)
    begin
        cycle_count++;
        if (boot_start === 1'b1)
            boot_cnt++;
        if (cycle_count == 10000)
        begin
            fail_count++;
            conclude();
        end
    end

    task check(input logic [14:0] seen, input logic [14:0] exp);
    begin
        check_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    end
    endtask : check

    task wait_idle;
        int n;
    begin
        n = 0;
        while (mem_busy !== 1'b0 && n < 400)
        begin
            @(posedge clock);
            #1;
            n++;
        end
        check({14'h0000, mem_busy}, 15'h0000);
    end
    endtask : wait_idle

    task load(input logic [14:0] value, input logic [13:0] mask);
    begin
        panel_u.set_sw(value);
        panel_u.press(SM);
        if (mask != 14'h0000)
            panel_u.press(mask);
    end
    endtask : load

    initial
    begin
        repeat (10) @(posedge clock);
        #1;
        rst = 1'b0;
        check(lamps, 15'h0000);
        check({14'h0000, intr_req}, 15'h0000);
        for (int i = 0; i < 5; i++)
        begin
            load(15'(4369 * (i + 1)), 14'(16 << i));
            check(lamps, 15'(4369 * (i + 1)));
            check(wreg[i], 15'(4369 * (i + 1)));
        end
        load(15'h0000, 14'h0000);
        for (int i = 0; i < 5; i++)
        begin
            panel_u.press(14'(512 << i));
            check(lamps, 15'(4369 * (i + 1)));
        end
        panel_u.set_sw(15'h7FFF);
        panel_u.press(OP);
        check({14'h0000, intr_req}, 15'h0001);
        check(sw_capture, 15'h7FFF);
        check(15'(boot_cnt), 15'h0000);
        intr_ack = 1'b1;
        @(posedge clock);
        #1;
        intr_ack = 1'b0;
        @(posedge clock);
        #1;
        check({14'h0000, intr_req}, 15'h0000);
        // Upper address bits set on purpose: only the low 13 reach the 8192-word core
        load(15'h2123, 14'h0040);
        load(15'h1357, 14'h0000);
        panel_u.press(CW);
        check({14'h0000, mem_busy}, 15'h0001);
        load(15'h0AAA, 14'h0000);
        wait_idle();
        check(lamps, 15'h1357);
        load(15'h0123, 14'h0040);
        panel_u.press(RR);
        wait_idle();
        check(lamps, 15'h1357);
        panel_u.press(RR);
        wait_idle();
        check(lamps, 15'h1357);
        panel_u.maint_load_sw = 1'b1;
        panel_u.press(OP);
        wait_idle();
        check(15'(boot_cnt), 15'h0001);
        check({2'b00, boot_addr}, 15'h0000);
        check(mar_out, 15'h0000);
        conclude();
    end
endmodule : test_operator_console_control
